// *** core/spims_clkgen.sv ***
// half-period tick generator for the master serial clock.
// assumes run is held high for a whole frame and dropped after it.
`timescale 1ns/100ps
module spims_clkgen
    import spims_pkg::*;
#(
    parameter int DW = 8
) (
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic          run,
    input  wire logic [DW-1:0] div,
    output logic               tick
);

    // ****************************************
    // half-period counter
    // ****************************************
    logic [DW-1:0] cnt_reg;
    logic [DW-1:0] cnt_next;

    // a tick every div+1 clocks gives f = fclk / (2 * (1 + div))
    assign tick = run && (cnt_reg == div);

    // counter restarts at every frame so the first half period is full
    always_comb begin
        if (!run || tick) begin
            cnt_next = '0;
        end else begin
            cnt_next = cnt_reg + {{(DW-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule : spims_clkgen

// *** core/spims_pkg.sv ***
// shared constants and carrier types for the serial peripheral port.
// assumes one 50 MHz clock that also stands in for the divider source clock.
package spims_pkg;

    // ****************************************
    // register map (byte offsets)
    // ****************************************
    localparam logic [7:0] SPIMS_OFS_TX   = 8'h00;
    localparam logic [7:0] SPIMS_OFS_RX   = 8'h04;
    localparam logic [7:0] SPIMS_OFS_STA  = 8'h08;
    localparam logic [7:0] SPIMS_OFS_DIV  = 8'h0c;
    localparam logic [7:0] SPIMS_OFS_CON  = 8'h10;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int         SPIMS_STA_TXV     = 0;
    localparam int         SPIMS_STA_BUSY    = 1;
    localparam int         SPIMS_STA_RXV     = 3;
    localparam int         SPIMS_STA_OVF     = 5;
    localparam logic [7:0] SPIMS_DIV_RST     = 8'h05;
    localparam logic [7:0] SPIMS_TX_IDLE     = 8'hff;
    localparam logic [2:0] SPIMS_CD_NOMASTER = 3'h6;
    localparam logic [2:0] SPIMS_BIT_LAST    = 3'h7;
    localparam logic [3:0] SPIMS_EDGE_LAST   = 4'hf;

    // control register layout, bit 0 upward: en, master, cpol, cpha
    typedef struct packed {
        logic [3:0] rsvd;
        logic       cpha;
        logic       cpol;
        logic       master;
        logic       en;
    } spims_ctrl_t;

    localparam spims_ctrl_t SPIMS_CTRL_RST = '0;

    typedef enum logic [1:0] {
        SPIMS_IDLE = 2'b01,
        SPIMS_XFER = 2'b10
    } spims_state_t;

endpackage : spims_pkg

// *** core/spims_port.sv ***
// byte-wide full-duplex serial port, master or slave, with holding registers.
// assumes pin inputs are synchronous to REF_CLK and a slave clock below fclk/4.
// Contract
// - eight bits each way per byte, most significant bit first on both lines.
// - master transfers never start while core clock divider reads 6 or 7.
// - control bit selects master operation or slave to an external master.
// - transmit byte goes through a shift register onto MOSI or MISO.
// - status bit 0 shows transmit holding register holds unmoved data.
// - status bit 3 shows receive holding register holds unread data.
// - status bit 5 sets when received data is overwritten or discarded.
// - MISO is input as master, output as slave.
// - MOSI is output as master, input as slave.
// - one byte takes eight serial clock periods, one bit each.
// - serial clock is driven as master, taken as input as slave.
// - master clock idle level and phase follow the control register.
// - master clock frequency is fclk over two times one plus divider.
// - slave samples and shifts with programmed polarity and phase.
// - data driven on one clock edge and sampled on the other.
// - slave frame runs while chip select is low, bytes until released.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module spims_port
    import spims_pkg::*;
(
    input  wire logic       REF_CLK,
    input  wire logic       SRST,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    input  wire logic [2:0] CORE_CLK_DIV,
    input  wire logic       MISO_I,
    output logic            MISO_O,
    output logic            MISO_OE,
    input  wire logic       MOSI_I,
    output logic            MOSI_O,
    output logic            MOSI_OE,
    input  wire logic       SCLK_I,
    output logic            SCLK_O,
    output logic            SCLK_OE,
    input  wire logic       CS_N_I,
    output logic            CS_N_O,
    output logic            CS_N_OE
);

    // ****************************************
    // state
    // ****************************************
    spims_state_t state_reg,     state_next;
    spims_ctrl_t  ctrl_reg,      ctrl_next;
    logic [7:0]   div_reg,       div_next;
    logic [7:0]   tx_hold_reg,   tx_hold_next;
    logic         tx_valid_reg,  tx_valid_next;
    logic [7:0]   rx_hold_reg,   rx_hold_next;
    logic         rx_valid_reg,  rx_valid_next;
    logic         ovf_reg,       ovf_next;
    logic [7:0]   tx_sh_reg,     tx_sh_next;
    logic [7:0]   rx_sh_reg,     rx_sh_next;
    logic         dout_reg,      dout_next;
    logic [2:0]   bit_cnt_reg,   bit_cnt_next;
    logic [3:0]   edge_cnt_reg,  edge_cnt_next;
    logic         byte_done_reg, byte_done_next;
    logic         sclk_reg,      sclk_next;
    logic         sclk_prev_reg, sclk_prev_next;
    logic         cs_n_reg,      cs_n_next;
    logic [7:0]   rdata_reg,     rdata_next;

    logic         tick;
    logic         is_master;
    logic         is_slave;
    logic         master_ok;
    logic         slave_lead;
    logic         slave_trail;
    logic         lead;
    logic         trail;
    logic         samp;
    logic         drv;
    logic         din;
    logic         byte_end;
    logic         load_now;
    logic [7:0]   load_byte;

    // ****************************************
    // helpers
    // ****************************************
    // first shift contents: cpha=1 drives bit 7 on the first leading edge
    function automatic logic [7:0] first_shift(input logic [7:0] b, input logic cpha);
        first_shift = cpha ? b : {b[6:0], 1'b0};
    endfunction : first_shift

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ****************************************
    // master clock divider
    // ****************************************
    spims_clkgen #(
        .DW   (8)
    ) u_clkgen (
        .clk  (REF_CLK),
        .srst (SRST),
        .run  ((state_reg == SPIMS_XFER) && is_master),
        .div  (div_reg),
        .tick (tick)
    );

    // mode decode and edge strobes, common to both roles
    assign is_master   = ctrl_reg.en && ctrl_reg.master;
    assign is_slave    = ctrl_reg.en && !ctrl_reg.master;
    assign master_ok   = CORE_CLK_DIV < SPIMS_CD_NOMASTER;
    // plain edge detect on the pin is safe only while sclk is below fclk/4
    assign slave_lead  = !CS_N_I && (SCLK_I != sclk_prev_reg) && (SCLK_I != ctrl_reg.cpol);
    assign slave_trail = !CS_N_I && (SCLK_I != sclk_prev_reg) && (SCLK_I == ctrl_reg.cpol);
    assign lead        = is_master ? (tick && !edge_cnt_reg[0]) : slave_lead;
    assign trail       = is_master ? (tick && edge_cnt_reg[0]) : slave_trail;
    assign samp        = (state_reg == SPIMS_XFER) && (ctrl_reg.cpha ? trail : lead);
    assign drv         = (state_reg == SPIMS_XFER) && (ctrl_reg.cpha ? lead : trail);
    assign din         = is_master ? MISO_I : MOSI_I;
    assign byte_end    = samp && (bit_cnt_reg == SPIMS_BIT_LAST);
    assign load_byte   = tx_valid_reg ? tx_hold_reg : SPIMS_TX_IDLE;

    // ****************************************
    // next-state logic: registers, frame control, shifters
    // ****************************************
    always_comb begin
        state_next     = state_reg;
        ctrl_next      = ctrl_reg;
        div_next       = div_reg;
        tx_hold_next   = tx_hold_reg;
        tx_valid_next  = tx_valid_reg;
        rx_hold_next   = rx_hold_reg;
        rx_valid_next  = rx_valid_reg;
        ovf_next       = ovf_reg;
        tx_sh_next     = tx_sh_reg;
        rx_sh_next     = rx_sh_reg;
        dout_next      = dout_reg;
        bit_cnt_next   = bit_cnt_reg;
        edge_cnt_next  = edge_cnt_reg;
        byte_done_next = byte_done_reg;
        sclk_next      = sclk_reg;
        sclk_prev_next = SCLK_I;
        cs_n_next      = cs_n_reg;
        rdata_next     = 8'h00;
        load_now       = 1'b0;

        // software reads; clears come first so hardware sets below win
        if (REG_RD) begin
            case (1'b1)
                hit(REG_ADDR, SPIMS_OFS_TX):  rdata_next = tx_hold_reg;
                hit(REG_ADDR, SPIMS_OFS_RX): begin
                    rdata_next    = rx_hold_reg;
                    rx_valid_next = 1'b0;
                end
                hit(REG_ADDR, SPIMS_OFS_STA): begin
                    rdata_next[SPIMS_STA_TXV]  = tx_valid_reg;
                    rdata_next[SPIMS_STA_BUSY] = (state_reg == SPIMS_XFER);
                    rdata_next[SPIMS_STA_RXV]  = rx_valid_reg;
                    rdata_next[SPIMS_STA_OVF]  = ovf_reg;
                    ovf_next                   = 1'b0;
                end
                hit(REG_ADDR, SPIMS_OFS_DIV): rdata_next = div_reg;
                hit(REG_ADDR, SPIMS_OFS_CON): rdata_next = ctrl_reg;
                default:                      rdata_next = 8'h00;
            endcase
        end

        case (state_reg)
            SPIMS_IDLE: begin
                edge_cnt_next  = 4'h0;
                bit_cnt_next   = 3'h0;
                byte_done_next = 1'b0;
                sclk_next      = ctrl_reg.cpol;
                cs_n_next      = 1'b1;
                if (is_master && master_ok && tx_valid_reg && cs_n_reg) begin
                    load_now   = 1'b1;
                    cs_n_next  = 1'b0;
                    state_next = SPIMS_XFER;
                end else if (is_slave && !CS_N_I) begin
                    load_now   = 1'b1;
                    state_next = SPIMS_XFER;
                end
                if (load_now) begin
                    tx_sh_next    = first_shift(load_byte, ctrl_reg.cpha);
                    dout_next     = load_byte[7];
                    tx_valid_next = 1'b0;
                end
            end
            SPIMS_XFER: begin
                if (is_master && tick) begin
                    sclk_next     = !sclk_reg;
                    edge_cnt_next = edge_cnt_reg + 4'h1;
                end
                // sample side: msb arrives first
                if (samp) begin
                    rx_sh_next   = {rx_sh_reg[6:0], din};
                    bit_cnt_next = bit_cnt_reg + 3'h1;
                end
                if (byte_end) begin
                    rx_hold_next   = {rx_sh_reg[6:0], din};
                    rx_valid_next  = 1'b1;
                    byte_done_next = 1'b1;
                    if (rx_valid_reg && !(REG_RD && hit(REG_ADDR, SPIMS_OFS_RX))) begin
                        ovf_next = 1'b1;
                    end
                end
                // drive side: next byte is fetched on the drive edge after a byte
                if (drv && byte_done_reg && is_slave) begin
                    tx_sh_next     = {load_byte[6:0], 1'b0};
                    dout_next      = load_byte[7];
                    tx_valid_next  = 1'b0;
                    byte_done_next = 1'b0;
                end else if (drv) begin
                    dout_next  = tx_sh_reg[7];
                    tx_sh_next = {tx_sh_reg[6:0], 1'b0};
                end
                // frame end: master after sixteen edges, slave on deselect;
                // chip select outlives the last edge by one clock, so a far end
                // sampling on that edge still sees itself selected
                if (is_master && tick && (edge_cnt_reg == SPIMS_EDGE_LAST)) begin
                    cs_n_next  = 1'b0;
                    state_next = SPIMS_IDLE;
                end else if (!ctrl_reg.en || (is_slave && CS_N_I)) begin
                    if (bit_cnt_reg != 3'h0) begin
                        ovf_next = 1'b1;
                    end
                    cs_n_next  = 1'b1;
                    state_next = SPIMS_IDLE;
                end
            end
            default: begin
                state_next = SPIMS_IDLE;
            end
        endcase

        // software writes; a write beside a load keeps the new byte valid
        if (REG_WR) begin
            case (1'b1)
                hit(REG_ADDR, SPIMS_OFS_TX): begin
                    tx_hold_next  = REG_WDATA;
                    tx_valid_next = 1'b1;
                end
                hit(REG_ADDR, SPIMS_OFS_DIV): div_next  = REG_WDATA;
                hit(REG_ADDR, SPIMS_OFS_CON): ctrl_next = {4'h0, REG_WDATA[3:0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state_reg     <= SPIMS_IDLE;
            ctrl_reg      <= SPIMS_CTRL_RST;
            div_reg       <= SPIMS_DIV_RST;
            tx_hold_reg   <= 8'h00;
            tx_valid_reg  <= 1'b0;
            rx_hold_reg   <= 8'h00;
            rx_valid_reg  <= 1'b0;
            ovf_reg       <= 1'b0;
            tx_sh_reg     <= 8'h00;
            rx_sh_reg     <= 8'h00;
            dout_reg      <= 1'b0;
            bit_cnt_reg   <= 3'h0;
            edge_cnt_reg  <= 4'h0;
            byte_done_reg <= 1'b0;
            sclk_reg      <= 1'b0;
            sclk_prev_reg <= 1'b0;
            cs_n_reg      <= 1'b1;
            rdata_reg     <= 8'h00;
        end else begin
            state_reg     <= state_next;
            ctrl_reg      <= ctrl_next;
            div_reg       <= div_next;
            tx_hold_reg   <= tx_hold_next;
            tx_valid_reg  <= tx_valid_next;
            rx_hold_reg   <= rx_hold_next;
            rx_valid_reg  <= rx_valid_next;
            ovf_reg       <= ovf_next;
            tx_sh_reg     <= tx_sh_next;
            rx_sh_reg     <= rx_sh_next;
            dout_reg      <= dout_next;
            bit_cnt_reg   <= bit_cnt_next;
            edge_cnt_reg  <= edge_cnt_next;
            byte_done_reg <= byte_done_next;
            sclk_reg      <= sclk_next;
            sclk_prev_reg <= sclk_prev_next;
            cs_n_reg      <= cs_n_next;
            rdata_reg     <= rdata_next;
        end
    end

    // ****************************************
    // pin drivers
    // ****************************************
    // slave drives miso only while selected so other slaves can share the line
    assign REG_RDATA = rdata_reg;
    assign MOSI_O    = dout_reg;
    assign MISO_O    = dout_reg;
    assign MOSI_OE   = is_master;
    assign MISO_OE   = is_slave && !CS_N_I;
    assign SCLK_O    = sclk_reg;
    assign SCLK_OE   = is_master;
    assign CS_N_O    = cs_n_reg;
    assign CS_N_OE   = is_master;

    // ****************************************
    // checks
    // ****************************************
    property p_no_master_start;
        @(posedge REF_CLK) disable iff (SRST)
        (state_reg == SPIMS_IDLE && is_master && !master_ok) |=> state_reg == SPIMS_IDLE;
    endproperty
    a_no_master_start: assert property (p_no_master_start)
        else $error("master start at cd 6/7");

    property p_tx_valid_set;
        @(posedge REF_CLK) disable iff (SRST)
        (REG_WR && REG_ADDR == SPIMS_OFS_TX) |=> tx_valid_reg && tx_hold_reg == $past(REG_WDATA);
    endproperty
    a_tx_valid_set: assert property (p_tx_valid_set)
        else $error("tx write not held valid");

    // a finished byte always lands as valid, even beside a receive read
    property p_rx_valid_set;
        @(posedge REF_CLK) disable iff (SRST)
        byte_end |=> rx_valid_reg;
    endproperty
    a_rx_valid_set: assert property (p_rx_valid_set)
        else $error("rx byte not flagged");

    property p_overflow;
        @(posedge REF_CLK) disable iff (SRST)
        (byte_end && rx_valid_reg && !REG_RD) |=> ovf_reg;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overwrite without overflow");

    property p_miso_dir;
        @(posedge REF_CLK) disable iff (SRST)
        is_master |-> !MISO_OE;
    endproperty
    a_miso_dir: assert property (p_miso_dir)
        else $error("miso driven as master");

    property p_mosi_dir;
        @(posedge REF_CLK) disable iff (SRST)
        is_slave |-> !MOSI_OE && !SCLK_OE && !CS_N_OE;
    endproperty
    a_mosi_dir: assert property (p_mosi_dir)
        else $error("slave drives master pins");

    property p_idle_pol;
        @(posedge REF_CLK) disable iff (SRST)
        (state_reg == SPIMS_IDLE && $past(state_reg) == SPIMS_IDLE && $stable(ctrl_reg))
            |-> SCLK_O == ctrl_reg.cpol;
    endproperty
    a_idle_pol: assert property (p_idle_pol)
        else $error("idle clock level wrong");

    property p_cs_frame;
        @(posedge REF_CLK) disable iff (SRST)
        (state_reg == SPIMS_XFER && is_master) |-> !CS_N_O;
    endproperty
    a_cs_frame: assert property (p_cs_frame)
        else $error("cs released mid byte");

    property p_msb_first;
        @(posedge REF_CLK) disable iff (SRST)
        (state_reg == SPIMS_IDLE && is_master && master_ok && tx_valid_reg && cs_n_reg && !REG_WR)
            |=> MOSI_O == $past(tx_hold_reg[7]) && !CS_N_O;
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("first bit is not msb");

endmodule : spims_port

// *** verification/spims_far_end.sv ***
// behavioural far-end serial device: slave while the port is master, master otherwise.
// assumes the bench resolves every shared line and clk runs at 50 MHz.
`timescale 1ns/100ps
module spims_far_end #(
    parameter int HALF = 4
) (
    input  wire logic        clk,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        mosi,
    input  wire logic        miso,
    input  wire logic        act_slave,
    input  wire logic        cpol,
    input  wire logic        cpha,
    input  wire logic [7:0]  tx_byte,
    output logic      [7:0]  rx_byte,
    output logic             sclk_m,
    output logic             cs_n_m,
    output logic             mosi_m,
    output logic             miso_s
);
    logic [7:0] sreg;
    logic       d_out;

    // ****************************************
    // slave role
    // ****************************************
    initial {sclk_m, cs_n_m, mosi_m, d_out} = 4'b0100;

    // cpha 0 must show the first bit before any clock edge
    always @(negedge cs_n) begin
        if (act_slave) begin
            rx_byte = 8'h00;
            sreg = cpha ? tx_byte : {tx_byte[6:0], 1'b0};
            d_out = cpha ? d_out : tx_byte[7];
        end
    end

    // sample on one edge, shift on the other
    always @(sclk) begin
        if (act_slave && !cs_n) begin
            if ((sclk != cpol) ^ cpha)
                rx_byte = {rx_byte[6:0], mosi};
            else begin
                d_out = sreg[7];
                sreg = {sreg[6:0], 1'b0};
            end
        end
    end

    // a released line shows the opposite of its last bit, not a held value
    assign miso_s = cs_n ? ~d_out : d_out;

    // ****************************************
    // master role
    // ****************************************
    // two bytes in one frame; the clock stands still outside it
    task automatic frame(input logic [15:0] b, output logic [15:0] got);
        int k;
        int idx;
        got = 16'h0000;
        @(posedge clk);
        sclk_m <= cpol;
        @(posedge clk);
        cs_n_m <= 1'b0;
        if (!cpha)
            mosi_m <= b[15];
        repeat (HALF) @(posedge clk);
        for (k = 0; k < 32; k++) begin
            sclk_m <= cpol ^ ~k[0];
            idx = 15 - (k + 1) / 2;
            if (~k[0] ^ cpha)
                got = {got[14:0], miso};
            else if (idx >= 0)
                mosi_m <= b[idx];
            repeat (HALF) @(posedge clk);
        end
        cs_n_m <= 1'b1;
        mosi_m <= ~mosi_m;
    endtask : frame
endmodule : spims_far_end

// *** verification/tb_top.sv ***
// self-checking bench: register tasks, far-end model, half-period monitor.
// assumes one 50 MHz clock and the far-end model on the serial lines.
`timescale 1ns/100ps
module tb_top
    import spims_pkg::*;
;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [2:0]  cdiv = 3'h0;
    logic        cpol = 1'b0;
    logic        cpha = 1'b0;
    logic        far_slave = 1'b1;
    logic [7:0]  far_tx = 8'h00;
    logic [7:0]  div = 8'h05;
    wire  [7:0]  rdata, far_rx;
    wire         miso_o, miso_oe, mosi_o, mosi_oe, sclk_o, sclk_oe, cs_n_o, cs_oe;
    wire         sclk_m, cs_n_m, mosi_m, miso_s;
    int          n_mismatch = 0;
    int          compares = 0;
    int          hp = 0;
    logic        cs_q = 1'b1;
    logic        sclk_q = 1'b0;

    // whoever holds the enable drives the line
    wire miso = miso_oe ? miso_o : miso_s;
    wire mosi = mosi_oe ? mosi_o : mosi_m;
    wire sclk = sclk_oe ? sclk_o : sclk_m;
    wire cs_n = cs_oe ? cs_n_o : cs_n_m;

    always #10 clk = ~clk;

    spims_port i_dut (.REF_CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .CORE_CLK_DIV(cdiv), .MISO_I(miso),
        .MISO_O(miso_o), .MISO_OE(miso_oe), .MOSI_I(mosi), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe),
        .SCLK_I(sclk), .SCLK_O(sclk_o), .SCLK_OE(sclk_oe), .CS_N_I(cs_n), .CS_N_O(cs_n_o),
        .CS_N_OE(cs_oe));
    spims_far_end i_far (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .act_slave(far_slave), .cpol(cpol), .cpha(cpha), .tx_byte(far_tx), .rx_byte(far_rx),
        .sclk_m(sclk_m), .cs_n_m(cs_n_m), .mosi_m(mosi_m), .miso_s(miso_s));

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe edge
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : reg_rd

    task automatic wait_cs(input logic v, input int lim);
        int n;
        n = 0;
        while (cs_n !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (cs_n !== v) begin
            n_mismatch++;
            complete_run();
        end
    endtask : wait_cs

    task automatic master_frame(input logic [7:0] b);
        reg_wr(SPIMS_OFS_TX, b);
        wait_cs(1'b0, 20);
        check("master pins", {miso_oe, mosi_oe, sclk_oe, cs_oe}, 8'h07);
        wait_cs(1'b1, 600);
        repeat (3) @(posedge clk);
    endtask : master_frame

    // each master half period lasts divider plus one clocks
    always @(posedge clk) begin
        hp = (cs_q === 1'b1) ? 0 : hp + 1;
        if (cs_n_o === 1'b0 && cs_q === 1'b0 && sclk_o !== sclk_q)
            check("half period", hp[7:0], div + 8'h01);
        if (sclk_o !== sclk_q)
            hp = 0;
        cs_q = cs_n_o;
        sclk_q = sclk_o;
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        logic [7:0]  d;
        logic [15:0] dd;
        int          m;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        check("idle pins", {miso_oe, mosi_oe, sclk_oe, cs_oe, cs_n_o}, 8'h01);
        reg_rd(SPIMS_OFS_STA, d);
        check("status", d, 8'h00);
        reg_rd(SPIMS_OFS_DIV, d);
        check("divider", d, SPIMS_DIV_RST);
        reg_rd(8'h14, d);
        check("unmapped", d, 8'h00);
        // master in all four clock modes
        for (m = 0; m < 4; m++) begin
            {cpha, cpol} = m[1:0];
            div = 8'h05 + 8'(m);
            far_tx = 8'h96 ^ 8'(m);
            reg_wr(SPIMS_OFS_DIV, div);
            reg_wr(SPIMS_OFS_CON, {4'h0, cpha, cpol, 2'b11});
            repeat (2) @(posedge clk);
            check("clock idle", sclk_o, cpol);
            master_frame(8'hc1 + 8'(m));
            check("far rx", far_rx, 8'hc1 + 8'(m));
            reg_rd(SPIMS_OFS_STA, d);
            check("status", d & 8'h29, 8'h08);
            reg_rd(SPIMS_OFS_RX, d);
            check("rx data", d, far_tx);
        end
        // divider settings 6 and 7 hold the byte back
        for (m = 6; m < 8; m++) begin
            @(posedge clk);
            cdiv <= 3'(m);
            reg_wr(SPIMS_OFS_TX, 8'h77);
            repeat (20) @(posedge clk);
            check("no start", cs_n_o, 1'b1);
            reg_rd(SPIMS_OFS_STA, d);
            check("tx pending", d & 8'h29, 8'h01);
        end
        @(posedge clk);
        cdiv <= 3'h0;
        wait_cs(1'b0, 20);
        wait_cs(1'b1, 600);
        far_tx = 8'he1;
        master_frame(8'h78);
        reg_rd(SPIMS_OFS_STA, d);
        check("overflow", d & 8'h29, 8'h28);
        reg_rd(SPIMS_OFS_STA, d);
        check("overflow clear", d & 8'h20, 8'h00);
        reg_rd(SPIMS_OFS_RX, d);
        check("newest rx", d, 8'he1);
        // slave: two bytes per frame, the second with an empty holding register
        far_slave = 1'b0;
        for (m = 0; m < 4; m++) begin
            {cpha, cpol} = m[1:0];
            reg_wr(SPIMS_OFS_CON, {4'h0, cpha, cpol, 2'b01});
            reg_wr(SPIMS_OFS_TX, 8'ha0 + 8'(m));
            i_far.frame(16'h3c53, dd);
            check("slave tx", dd[15:8], 8'ha0 + 8'(m));
            check("fill byte", dd[7:0], SPIMS_TX_IDLE);
            repeat (3) @(posedge clk);
            check("slave pins", {mosi_oe, sclk_oe, cs_oe}, 8'h00);
            reg_rd(SPIMS_OFS_STA, d);
            check("slave status", d & 8'h29, 8'h28);
            reg_rd(SPIMS_OFS_RX, d);
            check("slave rx", d, 8'h53);
        end
        complete_run();
    end
endmodule : tb_top
